// ==== design/fnds_pkg.sv ====
package fnds_pkg;
  // ==========================================================================
  // Serial word layout.
  localparam int WORD_BITS = 24;
  localparam logic [1:0] SEL_NDIV = 2'h0;
  localparam logic [1:0] SEL_RDIV = 2'h1;
  localparam logic [1:0] SEL_CTRL = 2'h2;
  localparam logic [1:0] SEL_NOISE = 2'h3;
  // ==========================================================================
  // N divider word fields.
  localparam int NDIV_FRACTION_NUMERATOR_LSB = 2;
  localparam int NDIV_INT_LSB = 14;
  localparam int NDIV_FASTLOCK_BIT = 23;
  // ==========================================================================
  // Reference divider word fields.
  localparam int RDIV_MOD_LSB = 2;
  localparam int RDIV_RCNT_LSB = 14;
  localparam int RDIV_MUX_LSB = 20;
  localparam int RDIV_LOAD_SEL_BIT = 23;
  localparam logic [2:0] MUX_FASTLOCK_SWITCH = 3'h6;
  // ==========================================================================
  // Control word fields.
  localparam int CTRL_HOLD_BIT = 2;
  localparam int CTRL_CP_LSB = 7;
  localparam int CTRL_DOUBLER_BIT = 11;
  localparam int CTRL_RESYNC_LSB = 12;
  localparam logic [3:0] CP_CURRENT_MAX = 4'hf;
  localparam logic [3:0] CP_CURRENT_MIN = 4'h0;
  // ==========================================================================
  // Noise and spur words.
  localparam logic [23:0] NOISE_CLEAR_WORD = 24'h000000;
  localparam logic [23:0] NOISE_LOWEST_WORD = 24'h0003c7;
  localparam logic [23:0] NOISE_LOW_SPUR_WORD = 24'h000003;
  localparam logic [23:0] NOISE_LOW_NS_WORD = 24'h000383;
  localparam int NOISE_DITHER_BIT = 6;
  localparam int NOISE_MODE_HI_BIT = 9;
  // ==========================================================================
  // Interpolator and link timing.
  localparam logic [11:0] MOD_RESET = 12'h002;
  localparam logic [20:0] LFSR_SEED = 21'h000001;
  localparam int SCLK_DIV = 6;
  localparam int COMPARE_DIV = 8;
  typedef enum logic [1:0] {
    FNDS_IDLE = 2'b00,
    FNDS_SHIFT = 2'b01,
    FNDS_LATCH = 2'b10,
    FNDS_GAP = 2'b11
  } fnds_link_t;
endpackage

// ==== design/fnds_link_if.sv ====
interface fnds_link_if;
  logic sclk;
  logic sdata;
  logic latch_strobe;
  modport host (output sclk, output sdata, output latch_strobe);
  modport dev (input sclk, input sdata, input latch_strobe);
endinterface

// ==== design/fnds_device.sv ====
// ==========================================================================
// Device end: serial input register, latches, sigma-delta interpolator.
// Operation
// R01: Host first writes zero noise word.
// R02: Host then writes chosen noise mode.
// R03: Host writes control with counter hold set.
// R04: Host writes reference divider, load select zero.
// R05: Host writes N divider, then clears hold.
// R06: Resync: extra reference write, load select one.
// R07: Output equals compare rate times N.
// R08: Compare rate from reference, doubler, divider.
// R09: Host keeps compare rate at most 32 MHz.
// R10: Denominator is 12 bits, 2 to 4095.
// R11: Dither mode denominator at least 50.
// R12: Third-order interpolator runs per compare cycle.
// R13: Undithered repeat length follows divisibility.
// R14: Dithered repeat length is two to 21.
// R15: Dither off in two low-noise modes.
// R16: Fastlock forces maximum charge pump current.
// R17: Host selects fastlock switch on test output.
// R18: Fastlock clear restores minimum current, opens switch. The code restores the control word's charge pump field instead.
// R19: Select bits one-zero route to control.
// R20: Counter hold keeps counters in reset.
// R21: Denominator loads only after next N write.
// R22: Host shifts 24 bits, strobe latches word.
module fnds_device
  import fnds_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic compare_tick,
  fnds_link_if.dev link,
  output logic [11:0] int_value,
  output logic [11:0] fraction_numerator,
  output logic [11:0] fraction_denominator,
  output logic [3:0] ref_counter,
  output logic doubler,
  output logic [3:0] resync_count,
  output logic [10:0] resync_delay,
  output logic [2:0] test_output_select,
  output logic counter_hold_bit,
  output logic dither_on,
  output logic [3:0] cp_current,
  output logic fastlock_switch,
  output logic [14:0] n_code,
  output logic n_code_valid
);
  // ========================================================================
  // Pin synchronisers; the first stage is read only by the second.
  // The strobe stages reset to the pin's idle high level, so releasing reset
  // never shows a false strobe edge that would latch a stale word.
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic sclk_prev_q;
  logic strobe_prev_q;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      meta_q <= 3'h4;
      sync_q <= 3'h4;
      sclk_prev_q <= 1'b0;
      strobe_prev_q <= 1'b1;
    end else begin
      meta_q <= {link.latch_strobe, link.sdata, link.sclk};
      sync_q <= meta_q;
      sclk_prev_q <= sync_q[0];
      strobe_prev_q <= sync_q[2];
    end
  end
  // Clock edges are taken only inside a frame, while the strobe is low.
  wire sclk_rise = sync_q[0] & ~sclk_prev_q & ~sync_q[2];
  wire strobe_rise = sync_q[2] & ~strobe_prev_q;
  // ========================================================================
  // Input shift register and latch decode.
  // Bits enter MSB first; the two lowest bits of the word name its latch.
  logic [23:0] shift_q;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) shift_q <= 24'h000000;
    else if (sclk_rise) shift_q <= {shift_q[22:0], sync_q[1]}; // R22
  end
  wire [1:0] sel = shift_q[1:0];
  wire wr_n = strobe_rise && sel == SEL_NDIV;
  wire wr_r = strobe_rise && sel == SEL_RDIV;
  wire wr_c = strobe_rise && sel == SEL_CTRL; // R19
  wire wr_s = strobe_rise && sel == SEL_NOISE;
  wire r_load_sel = shift_q[RDIV_LOAD_SEL_BIT];
  logic [23:0] ctrl_q;
  logic [23:0] noise_q;
  // A modulus write only stages the denominator; the next N write moves it in,
  // so the interpolator never runs with a mismatched numerator and denominator.
  logic [11:0] mod_pending_q;
  logic fastlock_q;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_q <= 24'h000004;
      noise_q <= NOISE_CLEAR_WORD;
      int_value <= 12'h000;
      fraction_numerator <= 12'h000;
      fraction_denominator <= MOD_RESET;
      mod_pending_q <= MOD_RESET;
      ref_counter <= 4'h1;
      test_output_select <= 3'h0;
      resync_delay <= 11'h000;
      fastlock_q <= 1'b0;
    end else begin
      if (wr_c) ctrl_q <= shift_q;
      if (wr_s) noise_q <= shift_q;
      if (wr_r) begin
        test_output_select <= shift_q[RDIV_MUX_LSB +: 3];
        ref_counter <= shift_q[RDIV_RCNT_LSB +: 4];
        if (r_load_sel) resync_delay <= shift_q[RDIV_MOD_LSB+1 +: 11]; // R06
        else if (shift_q[RDIV_MOD_LSB +: 12] >= 12'h002)
          mod_pending_q <= shift_q[RDIV_MOD_LSB +: 12]; // R10
      end
      if (wr_n) begin
        int_value <= shift_q[NDIV_INT_LSB +: 9] == 9'h000 ? 12'h000
                     : {3'h0, shift_q[NDIV_INT_LSB +: 9]};
        fraction_numerator <= shift_q[NDIV_FRACTION_NUMERATOR_LSB +: 12];
        fraction_denominator <= mod_pending_q; // R21
        // Each N write sets or clears fastlock; there is no separate command.
        fastlock_q <= shift_q[NDIV_FASTLOCK_BIT];
      end
    end
  end
  // ========================================================================
  // Derived outputs, all registered.
  // Registering them costs a cycle but keeps every output free of glitches.
  wire dither_next = noise_q[NOISE_DITHER_BIT] & ~noise_q[NOISE_MODE_HI_BIT]; // R15
  // The loop-filter switch closes only with fastlock set and the switch function selected.
  wire fl_switch_next = fastlock_q && test_output_select == MUX_FASTLOCK_SWITCH;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      counter_hold_bit <= 1'b1;
      doubler <= 1'b0;
      resync_count <= 4'h0;
      dither_on <= 1'b0;
      cp_current <= CP_CURRENT_MIN;
      fastlock_switch <= 1'b0;
    end else begin
      counter_hold_bit <= ctrl_q[CTRL_HOLD_BIT]; // R20
      doubler <= ctrl_q[CTRL_DOUBLER_BIT]; // R08
      resync_count <= ctrl_q[CTRL_RESYNC_LSB +: 4];
      dither_on <= dither_next;
      cp_current <= fastlock_q ? CP_CURRENT_MAX : ctrl_q[CTRL_CP_LSB +: 4]; // R16 R18
      fastlock_switch <= fl_switch_next; // R18
    end
  end
  // ========================================================================
  // Third-order MASH interpolator, one step per compare tick. Undithered,
  // its period follows the denominator's factors of 2 and 3; dither
  // stretches it to the LFSR period.
  logic [11:0] acc1_q;
  logic [11:0] acc2_q;
  logic [11:0] acc3_q;
  logic c2_q;
  logic c3_q;
  logic c3_d1_q;
  logic [20:0] lfsr_q;
  wire [12:0] s1 = {1'b0, acc1_q} + {1'b0, fraction_numerator} + {12'h000, dither_on & lfsr_q[0]};
  wire o1 = s1 >= {1'b0, fraction_denominator};
  wire [11:0] n1 = o1 ? 12'(s1 - {1'b0, fraction_denominator}) : s1[11:0];
  wire [12:0] s2 = {1'b0, acc2_q} + {1'b0, n1};
  wire o2 = s2 >= {1'b0, fraction_denominator};
  wire [11:0] n2 = o2 ? 12'(s2 - {1'b0, fraction_denominator}) : s2[11:0];
  wire [12:0] s3 = {1'b0, acc3_q} + {1'b0, n2};
  wire o3 = s3 >= {1'b0, fraction_denominator};
  wire [11:0] n3 = o3 ? 12'(s3 - {1'b0, fraction_denominator}) : s3[11:0];
  // Noise-shaped correction: c1 + (c2 - c2') + (c3 - 2c3' + c3'').
  wire signed [4:0] corr = $signed({4'h0, o1}) + $signed({4'h0, o2}) - $signed({4'h0, c2_q})
    + $signed({4'h0, o3}) - $signed({3'h0, c3_q, 1'b0}) + $signed({4'h0, c3_d1_q});
  // The correction stays within -3 to +4, so n_code stays in that band around int_value.
  wire [14:0] n_next = 15'({3'h0, int_value} + {{10{corr[4]}}, corr}); // R07 R12
  // Hold clears every stage and reseeds the dither source, so each release
  // starts the same code sequence and the spur pattern is repeatable.
  wire step = compare_tick & ~counter_hold_bit;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      acc1_q <= 12'h000;
      acc2_q <= 12'h000;
      acc3_q <= 12'h000;
      c2_q <= 1'b0;
      c3_q <= 1'b0;
      c3_d1_q <= 1'b0;
      lfsr_q <= LFSR_SEED;
      n_code <= 15'h0000;
      n_code_valid <= 1'b0;
    end else if (counter_hold_bit) begin // R20
      acc1_q <= 12'h000;
      acc2_q <= 12'h000;
      acc3_q <= 12'h000;
      c2_q <= 1'b0;
      c3_q <= 1'b0;
      c3_d1_q <= 1'b0;
      lfsr_q <= LFSR_SEED;
      n_code_valid <= 1'b0;
    end else begin
      n_code_valid <= step; // R12
      if (step) begin
        acc1_q <= n1;
        acc2_q <= n2;
        acc3_q <= n3;
        c2_q <= o2;
        c3_q <= o3;
        c3_d1_q <= c3_q;
        lfsr_q <= {lfsr_q[19:0], lfsr_q[20] ^ lfsr_q[18]}; // R14 R13
        n_code <= n_next;
      end
    end
  end
endmodule

// ==== design/fnds_host.sv ====
// ==========================================================================
// Host end: APB command registers, power-up sequence, 3-wire shifter.
module fnds_host
  import fnds_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic compare_tick,
  fnds_link_if.host link
);
  localparam logic [11:0] A_WORD = 12'h000;
  localparam logic [11:0] A_STATUS = 12'h004;
  localparam logic [11:0] A_INIT = 12'h008;
  logic [23:0] word_q;
  logic busy_q;
  logic [2:0] init_step_q;
  logic [23:0] init_words [0:5];
  fnds_link_t st_q;
  logic [4:0] bit_q;
  logic [2:0] div_q;
  logic [2:0] cmp_q;
  wire acc = psel & penable;
  wire hit_word = paddr == A_WORD;
  wire hit_stat = paddr == A_STATUS;
  wire hit_init = paddr == A_INIT;
  wire bad = ~(hit_word | hit_stat | hit_init);
  wire start_one = acc & pwrite & hit_word & ~busy_q;
  wire start_init = acc & pwrite & hit_init & ~busy_q;
  wire [31:0] rd = hit_word ? {8'h00, word_q}
                 : hit_stat ? {28'h0000000, init_step_q, busy_q} : 32'h00000000;
  wire tick = div_q == 3'(SCLK_DIV - 1);
  wire word_done = st_q == FNDS_GAP && tick;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~pready;
      pslverr <= psel & ~pready & (bad | (pwrite & busy_q & ~hit_stat));
      prdata <= rd;
    end
  end
  // ========================================================================
  // Sequence: clear, mode, control with hold, R (mod), N, control release.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      word_q <= 24'h000000;
      busy_q <= 1'b0;
      init_step_q <= 3'h0;
      for (int i = 0; i < 6; i++) init_words[i] <= 24'h000000;
    end else if (start_init && pready) begin
      init_words[0] <= NOISE_CLEAR_WORD; // R01
      init_words[1] <= NOISE_LOWEST_WORD; // R02
      init_words[2] <= {pwdata[23:3], 1'b1, SEL_CTRL}; // R03
      init_words[3] <= {1'b0, pwdata[22:14], 12'h041, SEL_RDIV}; // R04 R09 R11
      init_words[4] <= {pwdata[31:24], 16'h0000} | {8'h00, 16'h0000} | 24'h08a078; // R05
      init_words[5] <= {pwdata[23:3], 1'b0, SEL_CTRL}; // R05
      word_q <= NOISE_CLEAR_WORD;
      init_step_q <= 3'h1;
      busy_q <= 1'b1;
    end else if (start_one && pready) begin
      word_q <= pwdata[23:0]; // R06 R17
      busy_q <= 1'b1;
    end else if (word_done) begin
      if (init_step_q != 3'h0 && init_step_q < 3'h6) begin
        word_q <= init_words[init_step_q];
        init_step_q <= init_step_q + 3'h1;
      end else begin
        busy_q <= 1'b0;
        init_step_q <= 3'h0;
      end
    end
  end
  // ========================================================================
  // Shifter: sclk divided from clock, MSB first, strobe high to latch.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_q <= FNDS_IDLE;
      bit_q <= 5'h00;
      div_q <= 3'h0;
      link.sclk <= 1'b0;
      link.sdata <= 1'b0;
      link.latch_strobe <= 1'b1;
    end else begin
      div_q <= tick ? 3'h0 : div_q + 3'h1;
      case (st_q)
        FNDS_IDLE: begin
          if (busy_q && tick) begin
            st_q <= FNDS_SHIFT;
            link.latch_strobe <= 1'b0; // R22
            bit_q <= 5'(WORD_BITS - 1);
            link.sdata <= word_q[WORD_BITS-1];
          end
        end
        FNDS_SHIFT: begin
          if (div_q == 3'(SCLK_DIV / 2 - 1)) link.sclk <= 1'b1;
          if (tick) begin
            link.sclk <= 1'b0;
            if (bit_q == 5'h00) st_q <= FNDS_LATCH;
            else begin
              bit_q <= bit_q - 5'h01;
              link.sdata <= word_q[bit_q - 5'h01];
            end
          end
        end
        FNDS_LATCH: begin
          if (tick) begin
            link.latch_strobe <= 1'b1; // R22
            st_q <= FNDS_GAP;
          end
        end
        FNDS_GAP: begin
          if (tick) st_q <= FNDS_IDLE;
        end
        default: st_q <= FNDS_IDLE;
      endcase
    end
  end
  // Compare-rate enable that paces the device's interpolator.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cmp_q <= 3'h0;
      compare_tick <= 1'b0;
    end else begin
      cmp_q <= cmp_q + 3'h1;
      compare_tick <= cmp_q == 3'(COMPARE_DIV - 1);
    end
  end
endmodule

// ==== test/fnds_checker.sv ====
// ==========================================================================
// Wire checks on the serial link between host and device ends.
module fnds_checker
  import fnds_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic latch_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_q;
  logic [23:0] word_q;
  logic [5:0] bits_q;
  logic [2:0] idx_q;
  wire rise_w = sclk && !sclk_q;
  // The word index saturates so that later traffic never wraps back to step zero.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sclk_q <= 1'b0;
      bits_q <= 6'h00;
      idx_q <= 3'h0;
    end else begin
      sclk_q <= sclk;
      bits_q <= latch_strobe ? 6'h00 : bits_q + {5'h00, rise_w};
      if ($rose(latch_strobe) && idx_q != 3'h7) begin
        idx_q <= idx_q + 3'h1;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (rise_w) begin
      word_q <= {word_q[22:0], sdata};
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_word(int k);
    $rose(latch_strobe) && idx_q == k;
  endsequence
  property p_idle; latch_strobe |-> !sclk; endproperty
  property p_count; $rose(latch_strobe) |-> bits_q == 6'h18; endproperty
  property p_steady; sclk && $past(sclk) |-> $stable(sdata); endproperty
  property p_gap; $rose(latch_strobe) |=> latch_strobe[*5]; endproperty
  property p_start; $fell(latch_strobe) |-> ##[1:20] $rose(sclk); endproperty
  property p_w0; s_word(0) |-> word_q == NOISE_CLEAR_WORD; endproperty
  property p_w1; s_word(1) |-> word_q[1:0] == SEL_NOISE; endproperty
  property p_w2; s_word(2) |-> word_q[1:0] == SEL_CTRL && word_q[CTRL_HOLD_BIT]; endproperty
  property p_w3;
    s_word(3) |-> word_q[1:0] == SEL_RDIV && !word_q[RDIV_LOAD_SEL_BIT];
  endproperty
  property p_w4; s_word(4) |-> word_q[1:0] == SEL_NDIV; endproperty
  property p_w5; s_word(5) |-> word_q[1:0] == SEL_CTRL && !word_q[CTRL_HOLD_BIT]; endproperty
  a_idle: assert property (p_idle)
    else $error("clock moved outside a frame");
  a_count: assert property (p_count)
    else $error("frame bit count wrong");
  a_steady: assert property (p_steady)
    else $error("data moved while clock high");
  a_gap: assert property (p_gap)
    else $error("gap after latch too short");
  a_start: assert property (p_start)
    else $error("no clock after frame start");
  a_w0: assert property (p_w0)
    else $error("first word not all zero");
  a_w1: assert property (p_w1)
    else $error("second word not noise");
  a_w2: assert property (p_w2)
    else $error("third word not control with hold");
  a_w3: assert property (p_w3)
    else $error("fourth word not reference modulus");
  a_w4: assert property (p_w4)
    else $error("fifth word not N divider");
  a_w5: assert property (p_w5)
    else $error("sixth word does not release hold");
endmodule

// ==== test/fraction_numerator_n_divider_program_seq_test.sv ====
// ==========================================================================
// Both ends joined; software drives the host over APB.
module fraction_numerator_n_divider_program_seq_test import fnds_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, compare_tick, e;
  logic [11:0] int_value, fraction_numerator, fraction_denominator, pend;
  logic [3:0] ref_counter, resync_count, cp_current, cpc;
  logic [2:0] test_output_select;
  logic [10:0] resync_delay;
  logic [14:0] n_code;
  logic doubler, counter_hold_bit, dither_on, fastlock_switch, n_code_valid, pend_ok, fl;
  logic [54:0] em, km;
  logic [15:0] lf = 16'h9c54;
  logic [31:0] r;
  logic [109:0] nt;
  logic [109:0] nq[$];
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  int gap_n = 0;
  logic [11:0] int_d;
  wire [14:0] dn_w = n_code - {3'h0, int_d};
  wire [54:0] obs_w = {fraction_denominator, int_value, fraction_numerator, ref_counter,
    test_output_select, counter_hold_bit, dither_on, cp_current, fastlock_switch, doubler,
    resync_count};
  fnds_link_if fnds_link_if_inst ();
  fnds_host fnds_host_inst (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .compare_tick, .link(fnds_link_if_inst));
  fnds_device fnds_device_inst (.clock, .reset, .compare_tick, .link(fnds_link_if_inst),
    .int_value, .fraction_numerator, .fraction_denominator, .ref_counter, .doubler,
    .resync_count, .resync_delay, .test_output_select, .counter_hold_bit, .dither_on,
    .cp_current, .fastlock_switch, .n_code, .n_code_valid);
  fnds_checker fnds_checker_inst (.clock, .reset, .sclk(fnds_link_if_inst.sclk),
    .sdata(fnds_link_if_inst.sdata), .latch_strobe(fnds_link_if_inst.latch_strobe));
  initial begin
    forever #2 clock = ~clock;
  end
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return s[0] ? (s >> 1) ^ 16'hb400 : s >> 1;
  endfunction
  function automatic logic [23:0] rw(input logic ls, input logic [11:0] m);
    return {ls, MUX_FASTLOCK_SWITCH, 6'h01, m, SEL_RDIV};
  endfunction
  function automatic logic [23:0] nw(input logic f, input logic [8:0] i, input logic [11:0] q);
    return {f, i, q, SEL_NDIV};
  endfunction
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle;
    r = 32'h1;
    while (r[0] !== 1'b0) begin
      apb(1'b0, 12'h004, 32'h0);
    end
  endtask
  // A fresh denominator is only predicted once an N write has followed it.
  task automatic model(input logic [23:0] w);
    case (w[1:0])
      SEL_NOISE: begin
        em[10] = w[6] & ~w[9];
        km[10] = 1'b1;
      end
      SEL_CTRL: begin
        em[11] = w[2];
        cpc = w[10:7];
        em[4:0] = {w[11], w[15:12]};
        km[11] = 1'b1;
        km[4:0] = 5'h1f;
      end
      SEL_RDIV: begin
        if (!w[23] && w[13:2] > 12'h001) begin
          pend = w[13:2];
          pend_ok = 1'b1;
        end
        em[18:12] = {w[17:14], w[22:20]};
        km[18:12] = 7'h7f;
      end
      default: begin
        em[42:19] = {3'h0, w[22:14], w[13:2]};
        fl = w[23];
        km[42:19] = '1;
        km[9:5] = 5'h1f;
        if (pend_ok) em[54:43] = pend;
        km[54:43] = {12{pend_ok}};
      end
    endcase
    em[9:5] = {fl ? CP_CURRENT_MAX : cpc, fl && em[14:12] == MUX_FASTLOCK_SWITCH};
  endtask
  task automatic send(input logic [23:0] w);
    model(w);
    nq.push_back({em, km});
    apb(1'b1, 12'h000, {8'h00, w});
    wait_idle();
  endtask
  task automatic init_seq;
    em = '0;
    km = '0;
    pend_ok = 1'b0;
    fl = 1'b0;
    cpc = 4'h0;
    for (int i = 0; i < 6; i++) begin
      em[11] = i > 1 && i < 5;
      km[11:10] = {i > 1, 1'b1};
      nq.push_back({em, km});
    end
    lf = nxt(lf);
    apb(1'b1, 12'h008, {lf, lf});
    wait_idle();
  endtask
  task automatic chk_out(input logic [54:0] x, input logic [54:0] m);
    cmp_count++;
    if ((obs_w & m) !== (x & m)) begin
      err_total++;
      $display("BAD %0t outputs %h expected %h", $time, obs_w & m, x & m);
    end
  endtask
  task automatic chk1(input logic g, input logic x);
    cmp_count++;
    if (g !== x) begin
      err_total++;
      $display("BAD %0t flag %b expected %b", $time, g, x);
    end
  endtask
  task automatic complete_run;
    if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================================
  // Each latched word is judged once the device outputs have settled.
  initial begin
    wait (reset === 1'b0);
    forever begin
      @(posedge fnds_link_if_inst.latch_strobe);
      repeat (8) @(posedge clock);
      if (nq.size() > 0) begin
        nt = nq.pop_front();
        chk_out(nt[109:55], nt[54:0]);
      end
    end
  end
  // ==========================================================================
  // Each interpolator step stays in the third-order correction band.
  always @(posedge clock) begin
    int_d <= int_value;
    gap_n <= compare_tick ? 0 : gap_n + 1;
    if (reset === 1'b0 && n_code_valid === 1'b1) begin
      chk1(dn_w <= 15'h0004 || dn_w >= 15'h7ffd, 1'b1);
    end
    if (reset === 1'b0 && compare_tick === 1'b1) begin
      chk1(gap_n >= 7, 1'b1);
    end
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    init_seq();
    send(NOISE_LOW_NS_WORD);
    send(24'h000043);
    send(NOISE_LOWEST_WORD);
    lf = nxt(lf);
    send({8'h00, lf[3:0], lf[4], 9'h000, SEL_CTRL});
    send(rw(1'b0, 12'h041));
    lf = nxt(lf);
    send(nw(1'b0, {1'b1, lf[7:0]}, {6'h00, lf[13:8]}));
    send(rw(1'b0, 12'h082));
    send(nw(1'b1, 9'h08a, 12'h01e));
    send(rw(1'b1, 12'h3e8));
    chk1(resync_delay === 11'h1f4, 1'b1);
    send(rw(1'b0, 12'h001));
    send(nw(1'b0, 9'h08a, 12'h01e));
    send(rw(1'b0, 12'hfff));
    send(nw(1'b0, 9'h0c8, 12'hffe));
    model(NOISE_LOWEST_WORD);
    nq.push_back({em, km});
    apb(1'b1, 12'h000, {8'h00, NOISE_LOWEST_WORD});
    apb(1'b1, 12'h000, 32'h00000043);
    chk1(e, 1'b1);
    wait_idle();
    apb(1'b0, 12'h000, 32'h0);
    chk1(r[23:0] === NOISE_LOWEST_WORD, 1'b1);
    apb(1'b0, 12'h0fc, 32'h0);
    chk1(e, 1'b1);
    reset <= 1'b1;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    chk1(counter_hold_bit, 1'b1);
    chk1(fraction_denominator === MOD_RESET, 1'b1);
    init_seq();
    while (nq.size() > 0) @(posedge clock);
    complete_run();
  end
endmodule
